//--- design/csa_top.sv
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
// Summary of operation
// - Fetch codes 00/01/10; request only with room
// - Fetch state 11 holds request until acknowledged
// - Source switch codes idle/block/stop/drain
// - Switch: block parser, stop fetch, drain FIFO
// - Arbiter codes for idle, rings and batches
// - Low to interrupt ring passes state 0010
// - Batch entry passes 0100 or 0110
// - Wait-for-event from interrupt ring enters 1000
// - Parser 0000 idle, 0001 awaits idle engines
// - State 0101 flushes cache after engines done
// - Store: 0110, 0111, then holds 1000, 1001
// - Parse pointer gives dword offset in batch
// - Batch start/end captured with source ring
// - Stack-resumed batch leaves captures untouched
// - Fetch register shows address and fetch user
// - Memory mode bit 5 set disables prefetch
// - Error master bit cleared in two writes
// - Error master gathers four masked causes
// - Sync bit toggles after flush completes
// - Primary flip pending set, cleared on flip
// - Overlay flip pending cleared at vertical blank
module csa_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic low_ring_valid,
  input wire logic intr_ring_valid,
  input wire logic [22:0] ring_fetch_addr,
  input wire logic batch_req,
  input wire logic batch_from_stack,
  input wire logic [22:0] batch_start,
  input wire logic [22:0] batch_end,
  input wire logic batch_done,
  input wire logic fifo_room,
  input wire logic fifo_empty,
  input wire logic mem_ack,
  output logic mem_req,
  output logic [22:0] fetch_addr,
  output logic fifo_pop,
  input wire logic hdr_valid,
  input wire csa_pkg::csa_kind_t hdr_kind,
  input wire logic ext_xfer,
  output logic hdr_ready,
  input wire logic engines_idle,
  input wire logic flush_done,
  output logic cache_flush_req,
  output logic store_addr_phase,
  output logic store_data_phase,
  output logic ext_hold,
  input wire logic pri_flip_done,
  input wire logic vblank,
  input wire logic err_refresh,
  input wire logic err_page_table,
  input wire logic err_underrun,
  input wire logic err_parser,
  output logic prefetch_disable
);
  import csa_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    csa_sw_t sw; // Source switch machine
    csa_arb_t arb; // Ring arbiter machine
    csa_cpr_t cpr; // Parser machine
    logic [PTR_W-1:0] ptr; // Dword offset inside batch
    logic [ADDR_W-1:0] bstart; // Captured batch start
    logic [ADDR_W-1:0] bend; // Captured batch end
    logic [1:0] bsrc; // Ring that launched the batch
    logic [ADDR_W-1:0] faddr; // Current fetch address
    logic [31:0] mmode; // Memory interface mode
    logic sync_en; // Sync flush enable
    logic sync_tgl; // Sync status toggle
    logic pflip; // Primary flip pending
    logic oflip; // Overlay flip pending
    logic [IRQ_W-1:0] ident; // Sticky identity bits
    logic [ERR_W-1:0] errid; // Sticky error causes
    logic [ERR_W-1:0] errmask; // Error mask, 1 = masked
    logic rsp; // Bus answer cycle
    logic [31:0] rdata; // Read data
  } csa_top_state_t;

  csa_top_state_t s_r; // Registered state
  csa_top_state_t s_nxt; // Next state
  csa_dma_t dma_st; // Fetch machine state
  logic fetch_done; // Fetch machine idle
  logic fetch_run; // Arbiter wants fetch
  logic active; // A source is being parsed
  logic in_batch; // Parsing a batch buffer
  logic block; // Parser held by the switch
  logic take; // Header accepted this cycle
  logic sw_done; // Switch sequence completes
  logic wr; // Write commits this cycle
  logic [31:0] wm; // Write data under byte enables
  logic [31:0] rd_word; // Read mux output
  logic err_master; // Any unmasked error cause
  logic [ERR_W-1:0] err_set; // Error cause pulses
  logic [IRQ_W-1:0] id_set; // Identity set pulses

  // Expand byte enables to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{be[i]}};
    return m;
  endfunction

  // Write-one-to-clear bits for one register
  function automatic logic [31:0] w1c(input logic hit,
                                      input logic [31:0] d);
    return hit ? d : '0;
  endfunction

  // ----------------------------------------------------------------
  // Fetch FIFO machine
  // ----------------------------------------------------------------
  csa_fetch_fsm u_fetch (
    .mclk(mclk),
    .rst(rst),
    .run(fetch_run),
    .stop(s_r.sw == SW_STOP),
    .room(fifo_room),
    .ack(mem_ack),
    .mem_req(mem_req),
    .done(fetch_done),
    .state_o(dma_st)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    active = s_r.arb inside {ARB_LOW, ARB_INTR, ARB_LBAT, ARB_IBAT};
    in_batch = s_r.arb inside {ARB_LBAT, ARB_IBAT};
    fetch_run = active;
    block = s_r.sw != SW_IDLE;
    take = active && !block && s_r.cpr == CPR_IDLE && hdr_valid;
    sw_done = s_r.sw == SW_POP && fifo_empty && fetch_done;
    wr = avs_write && s_r.rsp;
    wm = avs_writedata & be_mask(avs_byteenable);
    err_set = '0;
    id_set = '0;

    // Source switch: block, stop fetch, drain
    case (s_r.sw)
      SW_IDLE: begin
        if (s_r.arb inside {ARB_L2I, ARB_L2B, ARB_I2B, ARB_I2D})
          s_nxt.sw = SW_BLOCK;
      end
      SW_BLOCK: if (s_r.cpr == CPR_IDLE) s_nxt.sw = SW_STOP;
      SW_STOP: if (fetch_done) s_nxt.sw = SW_POP;
      SW_POP: if (sw_done) s_nxt.sw = SW_IDLE;
      default: s_nxt.sw = SW_IDLE;
    endcase

    // Ring arbiter; the parser masks a ring by leaving it
    case (s_r.arb)
      ARB_IDLE: begin
        if (intr_ring_valid) s_nxt.arb = ARB_INTR;
        else if (low_ring_valid) s_nxt.arb = ARB_LOW;
        if (intr_ring_valid || low_ring_valid) s_nxt.faddr = ring_fetch_addr;
      end
      ARB_LOW: begin
        if (intr_ring_valid) s_nxt.arb = ARB_L2I;
        else if (batch_req) s_nxt.arb = ARB_L2B;
        else if (!low_ring_valid) s_nxt.arb = ARB_IDLE;
      end
      ARB_INTR: begin
        if (take && hdr_kind == K_EVENT) s_nxt.arb = ARB_I2D;
        else if (batch_req) s_nxt.arb = ARB_I2B;
        else if (!intr_ring_valid) s_nxt.arb = ARB_IDLE;
      end
      ARB_L2I: if (sw_done) s_nxt.arb = ARB_INTR;
      ARB_L2B: if (sw_done) s_nxt.arb = ARB_LBAT;
      ARB_I2B: if (sw_done) s_nxt.arb = ARB_IBAT;
      ARB_I2D: if (sw_done) s_nxt.arb = ARB_IDLE;
      ARB_LBAT: if (batch_done) s_nxt.arb = ARB_LOW;
      ARB_IBAT: if (batch_done) s_nxt.arb = ARB_INTR;
      default: s_nxt.arb = ARB_IDLE;
    endcase

    // Capture batch bounds, except when resumed from the stack
    if (batch_req && !batch_from_stack && !block &&
        s_r.arb inside {ARB_LOW, ARB_INTR}) begin
      s_nxt.bstart = batch_start;
      s_nxt.bend = batch_end;
      s_nxt.bsrc = s_r.arb == ARB_LOW ? SRC_LOW : SRC_INTR;
    end

    // Fetch address reloads at a switch and steps per accepted fetch
    if (sw_done) begin
      if (s_r.arb inside {ARB_L2B, ARB_I2B}) s_nxt.faddr = s_r.bstart;
      else s_nxt.faddr = ring_fetch_addr;
    end else if (mem_req && mem_ack) begin
      s_nxt.faddr = s_r.faddr + ADDR_W'(1);
    end

    // Parse pointer restarts at each batch entry
    if (sw_done) s_nxt.ptr = '0;
    else if (take && in_batch) s_nxt.ptr = s_r.ptr + PTR_W'(1);

    // Parser machine
    case (s_r.cpr)
      CPR_IDLE: begin
        if (take) begin
          case (hdr_kind)
            K_NONPIPE: s_nxt.cpr = CPR_SW;
            K_FLUSH: s_nxt.cpr = CPR_FLSH;
            K_STORE: s_nxt.cpr = CPR_STDA;
            K_EVENT: s_nxt.cpr = CPR_EVT;
            K_FAST: s_nxt.cpr = CPR_POPA;
            K_CMD: s_nxt.cpr = CPR_CMD;
            default: s_nxt.cpr = CPR_HDR;
          endcase
        end
      end
      CPR_SW: if (engines_idle) s_nxt.cpr = CPR_CMD;
      CPR_CMD: s_nxt.cpr = ext_xfer ? CPR_HLD1 : CPR_IDLE;
      CPR_STDA: s_nxt.cpr = CPR_STDW;
      CPR_STDW: s_nxt.cpr = CPR_HLD1;
      CPR_HLD1: s_nxt.cpr = CPR_HLD2;
      CPR_HLD2: s_nxt.cpr = CPR_IDLE;
      CPR_FLSH: if (engines_idle) s_nxt.cpr = CPR_WT;
      CPR_WT: begin
        // Toggle only once every engine has flushed
        if (flush_done) begin
          s_nxt.cpr = CPR_IDLE;
          if (s_r.sync_en) begin
            s_nxt.sync_tgl = !s_r.sync_tgl;
            id_set[B_SYNC] = 1'b1;
          end
        end
      end
      CPR_POPA: s_nxt.cpr = CPR_POPB;
      default: s_nxt.cpr = CPR_IDLE;
    endcase

    // Error causes and master bit
    err_set[E_REFRESH] = err_refresh;
    err_set[E_PTE] = err_page_table;
    err_set[E_UNDER] = err_underrun;
    err_set[E_PARSER] = err_parser;
    err_master = |(s_r.errid & ~s_r.errmask);
    id_set[B_ERR] = err_master;

    // Flip tracking; identity records flip occurred
    if (pri_flip_done && s_r.pflip) id_set[B_PFLIP] = 1'b1;
    if (vblank && s_r.oflip) id_set[B_OFLIP] = 1'b1;
    if (pri_flip_done) s_nxt.pflip = 1'b0;
    if (vblank) s_nxt.oflip = 1'b0;
    // A new flip packet wins over a same-cycle clear
    if (take && hdr_kind == K_PFLIP) s_nxt.pflip = 1'b1;
    if (take && hdr_kind == K_OFLIP) s_nxt.oflip = 1'b1;

    // Register writes; debug state fields have no write path
    if (wr && avs_address == OFS_MEMMODE) begin
      s_nxt.mmode = (s_r.mmode & ~be_mask(avs_byteenable)) |
                    (wm & MEMMODE_MASK);
    end
    if (wr && avs_address == OFS_ERRMASK) s_nxt.errmask = wm[ERR_W-1:0];
    if (s_r.cpr == CPR_WT && flush_done) s_nxt.sync_en = 1'b0;
    if (wr && avs_address == OFS_PMODE && avs_byteenable[0])
      s_nxt.sync_en = avs_writedata[B_SYNC_EN];
    // Sticky bits: a set in the clearing cycle survives
    s_nxt.errid = ERR_W'(32'(s_r.errid) & ~w1c(wr && avs_address ==
                  OFS_ERRID, wm)) | err_set;
    s_nxt.ident = IRQ_W'(32'(s_r.ident) & ~w1c(wr && avs_address ==
                  OFS_IDENT, wm)) | id_set;

    // Read mux, sampled in the first cycle of a read
    case (avs_address)
      OFS_PARSE_PTR: rd_word = 32'(s_r.ptr) << PTR_LSB;
      OFS_BSTART: rd_word = (32'(s_r.bstart) << ADDR_LSB) |
                            32'(s_r.bsrc);
      OFS_BEND: rd_word = (32'(s_r.bend) << ADDR_LSB) | 32'(s_r.bsrc);
      OFS_FADDR: rd_word = (32'(s_r.faddr) << ADDR_LSB) |
        32'(s_r.arb == ARB_LBAT ? USR_BLOW : s_r.arb == ARB_IBAT ?
            USR_BINTR : s_r.arb inside {ARB_INTR, ARB_I2B, ARB_I2D} ?
            SRC_INTR : SRC_LOW);
      OFS_MEMMODE: rd_word = s_r.mmode;
      OFS_IDENT: rd_word = 32'(s_r.ident);
      OFS_ERRID: rd_word = 32'(s_r.errid);
      OFS_ERRMASK: rd_word = 32'(s_r.errmask);
      OFS_PSTATE: rd_word = (32'(dma_st) << PS_DMA_LSB) |
        (32'(s_r.sw) << PS_SW_LSB) | (32'(s_r.arb) << PS_ARB_LSB) |
        32'(s_r.cpr);
      OFS_PMODE: rd_word = 32'(s_r.sync_en) << B_SYNC_EN;
      OFS_STATUS: rd_word = (32'(err_master) << B_ERR) |
        (32'(s_r.sync_tgl) << B_SYNC) | (32'(s_r.pflip) << B_PFLIP) |
        (32'(s_r.oflip) << B_OFLIP);
      default: rd_word = '0; // Unmapped reads as zero
    endcase

    // Every access waits exactly one cycle
    s_nxt.rsp = (avs_read || avs_write) && !s_r.rsp;
    if (avs_read && !s_r.rsp) s_nxt.rdata = rd_word;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !s_r.rsp;
  assign avs_readdata = s_r.rdata;
  assign fetch_addr = s_r.faddr;
  assign fifo_pop = s_r.sw == SW_POP && !fifo_empty;
  assign hdr_ready = active && !block && s_r.cpr == CPR_IDLE;
  assign cache_flush_req = s_r.cpr == CPR_FLSH && engines_idle;
  assign store_addr_phase = s_r.cpr == CPR_STDA;
  assign store_data_phase = s_r.cpr == CPR_STDW;
  assign ext_hold = s_r.cpr inside {CPR_HLD1, CPR_HLD2};
  assign prefetch_disable = s_r.mmode[B_PREF_DIS];

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.mmode <= MEMMODE_RST;
      s_r.errmask <= ERRMASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_store;
    s_r.cpr == CPR_STDW ##1 s_r.cpr == CPR_HLD1 ##1 s_r.cpr == CPR_HLD2;
  endsequence
  sequence seq_block_done;
    s_r.sw == SW_BLOCK && s_r.cpr == CPR_IDLE;
  endsequence
  AST_SW_ORDER: assert property (@(posedge mclk) disable iff (rst)
    seq_block_done |=> s_r.sw == SW_STOP ##1 s_r.sw inside {SW_STOP, SW_POP})
    else $error("switch did not move from block to stop");
  AST_L2I: assert property (@(posedge mclk) disable iff (rst)
    s_r.arb == ARB_LOW && intr_ring_valid |=> s_r.arb == ARB_L2I)
    else $error("low to interrupt switch skipped state 0010");
  AST_EVT: assert property (@(posedge mclk) disable iff (rst)
    s_r.arb == ARB_INTR && take && hdr_kind == K_EVENT |=>
    s_r.arb == ARB_I2D ##1 s_r.sw == SW_BLOCK)
    else $error("wait-for-event did not enter state 1000");
  AST_FLUSH: assert property (@(posedge mclk) disable iff (rst)
    s_r.cpr == CPR_FLSH && !engines_idle |=> s_r.cpr == CPR_FLSH)
    else $error("parser left flush state with busy engines");
  AST_STORE: assert property (@(posedge mclk) disable iff (rst)
    s_r.cpr == CPR_STDA |=> seq_store ##1 s_r.cpr == CPR_IDLE)
    else $error("store-dword sequence out of order");
  AST_STACK: assert property (@(posedge mclk) disable iff (rst)
    batch_req && batch_from_stack |=> $stable(s_r.bstart) && $stable(s_r.bend))
    else $error("stack-resumed batch reloaded the captures");
  AST_ERR: assert property (@(posedge mclk) disable iff (rst)
    err_parser && !s_r.errmask[E_PARSER] |=> ##1 s_r.ident[B_ERR])
    else $error("parser error did not raise the master bit");
  AST_SYNC: assert property (@(posedge mclk) disable iff (rst)
    s_r.cpr == CPR_WT && flush_done && s_r.sync_en |=>
    s_r.sync_tgl != $past(s_r.sync_tgl) && !s_r.sync_en)
    else $error("sync toggle missing after flush");
endmodule

//--- design/csa_pkg.sv
// ----------------------------------------------------------------
// Shared constants and types of the command stream front end
// ----------------------------------------------------------------
package csa_pkg;

  // Register byte offsets
  localparam logic [15:0] OFS_PARSE_PTR = 16'h20c8;
  localparam logic [15:0] OFS_BSTART = 16'h20cc;
  localparam logic [15:0] OFS_BEND = 16'h20d0;
  localparam logic [15:0] OFS_FADDR = 16'h20d4;
  localparam logic [15:0] OFS_MEMMODE = 16'h20dc;
  localparam logic [15:0] OFS_IDENT = 16'h2100;
  localparam logic [15:0] OFS_ERRID = 16'h2104;
  localparam logic [15:0] OFS_ERRMASK = 16'h2108;
  localparam logic [15:0] OFS_PSTATE = 16'h210c;
  localparam logic [15:0] OFS_PMODE = 16'h2110;
  localparam logic [15:0] OFS_STATUS = 16'h2114;

  // Field widths and positions
  localparam int ADDR_W = 23;
  localparam int ADDR_LSB = 3;
  localparam int PTR_W = 17;
  localparam int PTR_LSB = 2;
  localparam int IRQ_W = 16;
  localparam int ERR_W = 6;
  localparam int PS_DMA_LSB = 10;
  localparam int PS_SW_LSB = 8;
  localparam int PS_ARB_LSB = 4;
  localparam int B_ERR = 15;
  localparam int B_SYNC = 12;
  localparam int B_PFLIP = 11;
  localparam int B_OFLIP = 9;
  localparam int B_PREF_DIS = 5;
  localparam int B_SYNC_EN = 5;
  localparam int E_PARSER = 0;
  localparam int E_UNDER = 3;
  localparam int E_PTE = 4;
  localparam int E_REFRESH = 5;

  // Reset values and write masks
  localparam logic [31:0] MEMMODE_RST = 32'h0000_0000;
  localparam logic [31:0] MEMMODE_MASK = 32'h0000_0027;
  localparam logic [5:0] ERRMASK_RST = 6'h00;

  // Fetch user and batch source codes
  localparam logic [1:0] SRC_LOW = 2'h0;
  localparam logic [1:0] SRC_INTR = 2'h1;
  localparam logic [1:0] USR_BLOW = 2'h2;
  localparam logic [1:0] USR_BINTR = 2'h3;

  // Declaration order sets the debug codes of each machine
  typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_WAIT, DMA_RACK} csa_dma_t;
  typedef enum logic [1:0] {SW_IDLE, SW_BLOCK, SW_STOP, SW_POP} csa_sw_t;
  typedef enum logic [3:0] {ARB_IDLE, ARB_LOW, ARB_L2I, ARB_LBAT, ARB_L2B,
    ARB_INTR, ARB_I2B, ARB_IBAT, ARB_I2D} csa_arb_t;
  typedef enum logic [3:0] {CPR_IDLE, CPR_SW, CPR_HDR, CPR_CMD, CPR_EVT,
    CPR_FLSH, CPR_STDA, CPR_STDW, CPR_HLD1, CPR_HLD2, CPR_WT, CPR_POPA,
    CPR_POPB} csa_cpr_t;
  // Packet kinds decoded ahead of the parser
  typedef enum logic [2:0] {K_CMD, K_NONPIPE, K_FLUSH, K_STORE, K_EVENT,
    K_FAST, K_PFLIP, K_OFLIP} csa_kind_t;

endpackage

//--- design/csa_fetch_fsm.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Fetch FIFO request machine
// ----------------------------------------------------------------
module csa_fetch_fsm (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic stop,
  input wire logic room,
  input wire logic ack,
  output logic mem_req,
  output logic done,
  output csa_pkg::csa_dma_t state_o
);
  import csa_pkg::*;

  // All state of this machine
  typedef struct packed {
    csa_dma_t st;
  } csa_fetch_state_t;

  csa_fetch_state_t s_r; // Registered state
  csa_fetch_state_t s_nxt; // Next state
  logic quit; // Switch stops or arbiter withdraws the fetch

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    quit = stop || !run;
    case (s_r.st)
      DMA_IDLE: begin
        if (!quit) s_nxt.st = room ? DMA_REQ : DMA_WAIT;
      end
      DMA_REQ: begin
        if (quit) s_nxt.st = DMA_IDLE;
        else if (!room) s_nxt.st = DMA_WAIT;
        else if (!ack) s_nxt.st = DMA_RACK;
      end
      DMA_WAIT: begin
        // Stay until the FIFO frees a slot or the fetch quits
        if (quit) s_nxt.st = DMA_IDLE;
        else if (room) s_nxt.st = DMA_REQ;
      end
      DMA_RACK: begin
        // An issued request cannot be withdrawn, even on stop
        if (ack) s_nxt.st = quit ? DMA_IDLE : (room ? DMA_REQ : DMA_WAIT);
      end
      default: s_nxt.st = DMA_IDLE;
    endcase
  end

  // Request only with room, held while unacknowledged
  assign mem_req = (s_r.st == DMA_REQ && room && !quit) ||
                   s_r.st == DMA_RACK;
  assign done = s_r.st == DMA_IDLE;
  assign state_o = s_r.st;

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) s_r <= '{st: DMA_IDLE};
    else s_r <= s_nxt;
  end

  AST_WAIT_HOLD: assert property (@(posedge mclk) disable iff (rst)
    s_r.st == DMA_WAIT && !room && !quit |=> s_r.st == DMA_WAIT && !mem_req)
    else $error("fetch left wait state without room");
  AST_NO_ROOM: assert property (@(posedge mclk) disable iff (rst)
    s_r.st == DMA_REQ && !room |-> !mem_req)
    else $error("fetch request issued with a full FIFO");
  AST_RACK_HOLD: assert property (@(posedge mclk) disable iff (rst)
    s_r.st == DMA_RACK && !ack |=> s_r.st == DMA_RACK && mem_req)
    else $error("fetch request dropped before acknowledge");

endmodule

//--- test/csa_mem_model.sv
`timescale 1ns/1ns
// --------------------------------
// Memory fetch path and engine model
// --------------------------------
module csa_mem_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic cache_flush_req,
  input wire logic slow,
  output logic mem_ack,
  output logic fifo_room,
  output logic fifo_empty,
  output logic engines_idle,
  output logic flush_done
);
  int wait_n; // Cycles the open request has waited
  // Slow mode delays acks and starves room and idle on alternate cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_n <= 0;
      mem_ack <= 1'b0;
      fifo_room <= 1'b0;
      fifo_empty <= 1'b1;
      engines_idle <= 1'b0;
      flush_done <= 1'b0;
    end else begin
      mem_ack <= mem_req && !mem_ack && wait_n >= (slow ? 3 : 0);
      wait_n <= (mem_req && !mem_ack) ? wait_n + 1 : 0;
      fifo_room <= !slow || !fifo_room;
      fifo_empty <= !mem_req;
      engines_idle <= !slow || !engines_idle;
      flush_done <= cache_flush_req && !flush_done;
    end
  end
endmodule

//--- test/command_stream_arbiter_state_bench.sv
`timescale 1ns/1ns
// --------------------------------
// Self-checking bench of the command stream front end
// --------------------------------
module command_stream_arbiter_state_bench;
  import csa_pkg::*;
  logic mclk = 0, rst = 1, slow = 0, avs_read = 0, avs_write = 0;
  logic low_ring_valid = 0, intr_ring_valid = 0, batch_req = 0;
  logic batch_from_stack = 0, batch_done = 0, hdr_valid = 0, ext_xfer = 0;
  logic pri_flip_done = 0, vblank = 0;
  logic [3:0] avs_byteenable = 4'hf; // Whole words only
  logic [3:0] errs = 4'h0; // Error cause pulses
  logic [15:0] avs_address = 16'h0000;
  logic [31:0] avs_writedata = 32'h0, rd, exp_bs, exp_be, wd;
  logic [22:0] ring_fetch_addr = 23'h0, batch_start = 23'h0, batch_end = 23'h0;
  csa_kind_t hdr_kind = K_CMD;
  logic [31:0] avs_readdata;
  logic [22:0] fetch_addr;
  logic avs_waitrequest, mem_req, mem_ack, fifo_room, fifo_empty, fifo_pop;
  logic engines_idle, flush_done, hdr_ready, cache_flush_req, ext_hold;
  logic store_addr_phase, store_data_phase, prefetch_disable;
  wire err_refresh = errs[0];
  wire err_page_table = errs[1];
  wire err_underrun = errs[2];
  wire err_parser = errs[3];
  int miscompares = 0, tests_run = 0;
  int ebit[4] = '{E_REFRESH, E_PTE, E_UNDER, E_PARSER}; // Id bit per cause
  logic [15:0] ofs[6] = '{OFS_PARSE_PTR, OFS_BSTART, OFS_BEND, OFS_FADDR,
    OFS_MEMMODE, 16'h2200};

  always #2 mclk = ~mclk;
  csa_top dut (.*);
  csa_mem_model far (.*);

  // --------------------------------
  // Compare, report and bus tasks
  // --------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Request held until waitrequest is seen low, then released
  task bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
    if (n == 50) begin
      chk(32'h0, 32'h1);
      end_sim;
    end
  endtask
  task rd_chk(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Polls a field; a state that never arrives ends the run
  task wait_reg(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    for (n = 0; n < 100; n++) begin
      bus(1'b0, a, 32'h0);
      if ((rd & m) === e) break;
    end
    chk(rd & m, e);
    if (n == 100) end_sim;
  endtask
  task hdr(input csa_kind_t k);
    int n;
    hdr_kind <= k;
    hdr_valid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge mclk);
      if (hdr_ready === 1'b1) break;
    end
    hdr_valid <= 1'b0;
    if (n == 100) wait_reg(OFS_STATUS, 32'h0, 32'h1);
  endtask
  // Launches a batch; a stacked resume keeps the old captures
  task batch(input logic [1:0] src, input logic stk);
    batch_from_stack <= stk;
    batch_start <= 23'($urandom);
    batch_end <= 23'($urandom);
    batch_req <= 1'b1;
    @(posedge mclk);
    batch_req <= 1'b0;
    if (!stk) exp_bs = {6'h0, batch_start, 1'b0, src};
    if (!stk) exp_be = {6'h0, batch_end, 1'b0, src};
    wait_reg(OFS_PSTATE, 32'hf0, src == SRC_LOW ? 32'h30 : 32'h70);
    rd_chk(OFS_BSTART, 32'hffffffff, exp_bs);
    rd_chk(OFS_BEND, 32'hffffffff, exp_be);
    rd_chk(OFS_FADDR, 32'h3, {30'h0, src | 2'h2});
    hdr(K_CMD);
    rd_chk(OFS_PARSE_PTR, 32'hffffffff, 32'h4);
    batch_done <= 1'b1;
    @(posedge mclk);
    batch_done <= 1'b0;
    wait_reg(OFS_PSTATE, 32'hf0, src == SRC_LOW ? 32'h10 : 32'h50);
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    void'($urandom(70601));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (ofs[i]) rd_chk(ofs[i], 32'hffffffff, 32'h0);
    repeat (4) begin
      wd = $urandom;
      bus(1'b1, OFS_MEMMODE, wd);
      rd_chk(OFS_MEMMODE, 32'hffffffff, wd & MEMMODE_MASK);
      chk({31'h0, prefetch_disable}, {31'h0, wd[5]});
    end
    bus(1'b1, OFS_MEMMODE, 32'h4);
    bus(1'b1, OFS_BSTART, $urandom);
    rd_chk(OFS_BSTART, 32'hffffffff, 32'h0);
    bus(1'b1, OFS_PSTATE, 32'hffffffff);
    rd_chk(OFS_PSTATE, 32'hffffffff, 32'h0);
    // Low ring with a slow memory side, then batches
    ring_fetch_addr <= 23'($urandom);
    low_ring_valid <= 1'b1;
    slow <= 1'b1;
    wait_reg(OFS_PSTATE, 32'hf0, 32'h10);
    rd_chk(OFS_FADDR, 32'h3, {30'h0, SRC_LOW});
    batch(SRC_LOW, 1'b0);
    batch(SRC_LOW, 1'b1);
    ext_xfer <= 1'($urandom);
    hdr(K_STORE);
    @(posedge mclk);
    chk({31'h0, store_addr_phase}, 32'h1);
    @(posedge mclk);
    chk({31'h0, store_data_phase}, 32'h1);
    repeat (2) begin
      @(posedge mclk);
      chk({31'h0, ext_hold}, 32'h1);
    end
    // Plain command holds only when the transfer is external
    hdr(K_CMD);
    @(posedge mclk);
    repeat (2) begin
      @(posedge mclk);
      chk({31'h0, ext_hold}, {31'h0, ext_xfer});
    end
    hdr(K_NONPIPE);
    @(posedge mclk);
    hdr(K_FAST);
    @(posedge mclk);
    hdr(K_PFLIP);
    wait_reg(OFS_STATUS, 32'h800, 32'h800);
    pri_flip_done <= 1'b1;
    @(posedge mclk);
    pri_flip_done <= 1'b0;
    wait_reg(OFS_STATUS, 32'h800, 32'h0);
    hdr(K_OFLIP);
    wait_reg(OFS_STATUS, 32'h200, 32'h200);
    vblank <= 1'b1;
    @(posedge mclk);
    vblank <= 1'b0;
    wait_reg(OFS_STATUS, 32'h200, 32'h0);
    rd_chk(OFS_IDENT, 32'ha00, 32'ha00);
    bus(1'b0, OFS_STATUS, 32'h0);
    wd = (rd ^ 32'h1000) & 32'h1000;
    bus(1'b1, OFS_PMODE, 32'h20);
    hdr(K_FLUSH);
    wait_reg(OFS_STATUS, 32'h1000, wd);
    slow <= 1'b0;
    // Interrupt ring, its batch, then wait for event to idle
    low_ring_valid <= 1'b0;
    intr_ring_valid <= 1'b1;
    wait_reg(OFS_PSTATE, 32'hf0, 32'h50);
    rd_chk(OFS_FADDR, 32'h3, {30'h0, SRC_INTR});
    batch(SRC_INTR, 1'b0);
    hdr(K_EVENT);
    intr_ring_valid <= 1'b0;
    wait_reg(OFS_PSTATE, 32'hf0, 32'h0);
    // Each error cause raises the master bit; two writes clear it
    for (int i = 0; i < 4; i++) begin
      errs <= 4'h1 << i;
      @(posedge mclk);
      errs <= 4'h0;
      wait_reg(OFS_IDENT, 32'h8000, 32'h8000);
      bus(1'b1, OFS_ERRID, 32'h1 << ebit[i]);
      bus(1'b1, OFS_IDENT, 32'h8000);
      rd_chk(OFS_IDENT, 32'h8000, 32'h0);
    end
    bus(1'b1, OFS_ERRMASK, 32'h1 << E_UNDER);
    errs <= 4'h4;
    @(posedge mclk);
    errs <= 4'h0;
    repeat (4) @(posedge mclk);
    rd_chk(OFS_IDENT, 32'h8000, 32'h0);
    end_sim;
  end
endmodule
